// ==== hw/ups_sup_pkg.sv ====
// Constants shared by the UPS protection and panel supervisor.
// Assumes a 20 MHz system clock and a single synchronous reset.
package ups_sup_pkg;

  // ==========================================================
  // Timebase
  localparam int unsigned CLK_HZ        = 20_000_000;
  localparam int unsigned TICK_MS       = 100;
  localparam int unsigned TICK_CYCLES   = CLK_HZ / 1000 * TICK_MS;
  localparam int unsigned DEBOUNCE_MS   = 20;
  localparam int unsigned DEBOUNCE_CYC  = CLK_HZ / 1000 * DEBOUNCE_MS;

  // ==========================================================
  // Times in milliseconds and their tick counts
  localparam int unsigned OVL_MID_MS    = 12000;
  localparam int unsigned OVL_HIGH_MS   = 1500;
  localparam int unsigned BEEP_LINE_MS  = 4000;
  localparam int unsigned BEEP_LOW_MS   = 1000;
  localparam int unsigned BEEP_LEN_MS   = 200;
  localparam int unsigned HOLD_ON_MS    = 2000;
  localparam int unsigned HOLD_MUTE_MS  = 5000;
  localparam int unsigned HOLD_DEF_MS   = 10000;
  localparam int unsigned START_BYP_MS  = 10000;
  localparam int unsigned BATT_WARN_MS  = 5000;
  localparam int unsigned T_OVL_MID     = OVL_MID_MS / TICK_MS;
  localparam int unsigned T_OVL_HIGH    = OVL_HIGH_MS / TICK_MS;
  localparam int unsigned T_BEEP_LINE   = BEEP_LINE_MS / TICK_MS;
  localparam int unsigned T_BEEP_LOW    = BEEP_LOW_MS / TICK_MS;
  localparam int unsigned T_BEEP_LEN    = BEEP_LEN_MS / TICK_MS;
  localparam int unsigned T_HOLD_ON     = HOLD_ON_MS / TICK_MS;
  localparam int unsigned T_HOLD_MUTE   = HOLD_MUTE_MS / TICK_MS;
  localparam int unsigned T_HOLD_DEF    = HOLD_DEF_MS / TICK_MS;
  localparam int unsigned T_START_BYP   = START_BYP_MS / TICK_MS;
  localparam int unsigned T_BATT_WARN   = BATT_WARN_MS / TICK_MS;

  // ==========================================================
  // Fault codes and display selections
  localparam logic [3:0] FC_NONE  = 4'h0;
  localparam logic [3:0] FC_BUS   = 4'h1;
  localparam logic [3:0] FC_TEMP  = 4'h2;
  localparam logic [3:0] FC_INV   = 4'h3;
  localparam logic [3:0] FC_BATT  = 4'h4;
  localparam logic [3:0] FC_OVL   = 4'h5;
  localparam logic [2:0] SEL_LAST = 3'h4;
  // Sensor synchroniser reset: the thermal switch reads closed, so reset shows no false fault.
  localparam logic [11:0] SNS_RST = 12'h010;

  typedef enum logic [2:0] {
    UPS_OFF, UPS_START, UPS_LINE, UPS_BATT, UPS_BYPASS, UPS_STANDBY, UPS_FAIL, UPS_SETTING
  } ups_mode_e;

endpackage

// ==== hw/ups_sup.sv ====
// UPS protection and front-panel supervisor.
// Assumes sensor and key inputs are asynchronous levels and the pulse gate is on clk_sys.
module ups_sup #(
  parameter int unsigned DEB_CYC  = ups_sup_pkg::DEBOUNCE_CYC,
  parameter int unsigned TICK_CYC = ups_sup_pkg::TICK_CYCLES
) (
  input  wire logic       clk_sys,
  input  wire logic       rst_n,
  input  wire logic       ce,
  input  wire logic       key_on_n,
  input  wire logic       key_off_n,
  input  wire logic       key_sel_n,
  input  wire logic       mains_ok,
  input  wire logic       load_over_110,
  input  wire logic       load_over_130,
  input  wire logic       inv_overcurrent,
  input  wire logic       inv_fail,
  input  wire logic       batt_out_window,
  input  wire logic       batt_low,
  input  wire logic       batt_depleted,
  input  wire logic       thermal_closed,
  input  wire logic       bus_fault,
  input  wire logic       remote_shutdown,
  input  wire logic       self_test_done,
  input  wire logic       economy_mode,
  input  wire logic       converter_mode,
  input  wire logic       pwm_pulse,
  output logic            inv_gate_en,
  output logic            inv_enable,
  output logic            relay_bypass,
  output logic            buzzer,
  output logic            warning,
  output logic            muted,
  output logic [3:0]      fault_code,
  output logic [2:0]      disp_sel,
  output logic            setting_mode,
  output logic            self_test,
  output logic            defaults_restore
);

  // ==========================================================
  // Elaboration checks
  if (DEB_CYC < 2 || DEB_CYC > 1048575 || TICK_CYC < 2 || TICK_CYC > 16777215) begin : g_chk
    $error("ups_sup: counter parameter out of range.");
  end

  // ==========================================================
  // State
  typedef struct packed {
    logic [1:0]  s1_on, s2_on, s1_off, s2_off, s1_sel, s2_sel;
    logic [11:0] s1_sns, s2_sns;
    logic [2:0]  key_db;
    logic [2:0]  key_prev;
    logic [19:0] deb_cnt;
    logic [23:0] tick_cnt;
    logic        tick;
    ups_sup_pkg::ups_mode_e mode;
    logic [7:0]  t_ovl, t_beep, t_start, t_batt;
    logic [7:0]  h_on, h_off, h_sel, h_on_sel, h_on_off;
    logic        inv_latched;
    logic        oc_blank;
    logic        pulse_prev;
    logic        out_gate, out_inv_en, out_byp, out_buz, out_warn, out_mute;
    logic [3:0]  out_code;
    logic [2:0]  out_sel;
    logic        out_test, out_def, out_set;
  } ups_state_s;

  ups_state_s st_reg;
  ups_state_s st_next;

  // Returns one when a hold counter reaches its target on this tick.
  function automatic logic hold_hit(input logic [7:0] cnt, input int unsigned lim);
    hold_hit = (cnt == 8'(lim - 1));
  endfunction

  function automatic logic [7:0] hold_step(input logic [7:0] cnt, input logic qual, input logic tick);
    if (!qual) begin
      hold_step = 8'h00;
    end else if (tick && cnt != 8'hFF) begin
      hold_step = cnt + 8'h01;
    end else begin
      hold_step = cnt;
    end
  endfunction

  logic [2:0]  keys;
  logic [2:0]  press;
  logic [11:0] sns;
  logic [7:0]  beep_last;
  logic        k_on, k_off, k_sel, line_fail, any_warn, hard_fault, ovl;

  always_comb begin
    st_next = st_reg;
    // Sensor order: 110,130,oc,invf,battwin,low,depl,therm,bus,rsd,mains,pulse.
    sns     = st_reg.s2_sns;
    keys    = {st_reg.s2_sel[0], st_reg.s2_off[0], st_reg.s2_on[0]};
    // Two flops on every asynchronous input before logic reads them; only the 130 percent rise detect also reads the first flop.
    st_next.s1_on  = {1'b0, ~key_on_n};
    st_next.s2_on  = st_reg.s1_on;
    st_next.s1_off = {1'b0, ~key_off_n};
    st_next.s2_off = st_reg.s1_off;
    st_next.s1_sel = {1'b0, ~key_sel_n};
    st_next.s2_sel = st_reg.s1_sel;
    st_next.s1_sns = {load_over_110, load_over_130, inv_overcurrent, inv_fail, batt_out_window,
                      batt_low, batt_depleted, thermal_closed, bus_fault, remote_shutdown,
                      mains_ok, pwm_pulse};
    st_next.s2_sns = st_reg.s1_sns;

    // Debounce: keys must stay different from the accepted level for DEB_CYC cycles.
    if (keys == st_reg.key_db) begin
      st_next.deb_cnt = 20'h00000;
    end else if (st_reg.deb_cnt == 20'(DEB_CYC - 1)) begin
      st_next.deb_cnt = 20'h00000;
      st_next.key_db  = keys;
    end else begin
      st_next.deb_cnt = st_reg.deb_cnt + 20'h00001;
    end
    st_next.key_prev = st_reg.key_db;
    press = st_reg.key_db & ~st_reg.key_prev;
    k_on  = st_reg.key_db[0];
    k_off = st_reg.key_db[1];
    k_sel = st_reg.key_db[2];

    // Common slow tick for every second-scale timer.
    st_next.tick = 1'b0;
    if (st_reg.tick_cnt == 24'(TICK_CYC - 1)) begin
      st_next.tick_cnt = 24'h000000;
      st_next.tick     = 1'b1;
    end else begin
      st_next.tick_cnt = st_reg.tick_cnt + 24'h000001;
    end

    line_fail  = ~sns[1];
    ovl        = sns[11];
    hard_fault = st_reg.inv_latched | ~sns[4] | sns[3];
    any_warn   = ovl | sns[7] | sns[6] | hard_fault;
    beep_last  = sns[6] ? 8'(ups_sup_pkg::T_BEEP_LOW - 1) : 8'(ups_sup_pkg::T_BEEP_LINE - 1);

    // Hold counters clear as soon as their key pattern drops.
    st_next.h_on     = hold_step(st_reg.h_on, k_on & ~k_off & ~k_sel, st_reg.tick);
    st_next.h_off    = hold_step(st_reg.h_off, k_off & ~k_on & ~k_sel, st_reg.tick);
    st_next.h_sel    = hold_step(st_reg.h_sel, k_sel & ~k_on & ~k_off, st_reg.tick);
    st_next.h_on_sel = hold_step(st_reg.h_on_sel, k_on & k_sel & ~k_off, st_reg.tick);
    st_next.h_on_off = hold_step(st_reg.h_on_off, k_on & k_off & ~k_sel, st_reg.tick);
    st_next.out_def  = 1'b0;

    // Inverter failure latch, released only by switch-off or a depleted battery.
    if (sns[8]) begin
      st_next.inv_latched = 1'b1;
    end else if (st_reg.mode == ups_sup_pkg::UPS_OFF || sns[5]) begin
      st_next.inv_latched = 1'b0;
    end

    // Overload timer: 12 s band between 110 and 130, 1.5 s above 130.
    st_next.t_ovl = hold_step(st_reg.t_ovl, ovl, st_reg.tick);
    // A new rise above 130 percent restarts the count, so the short delay always runs in full.
    if (st_reg.s1_sns[10] && !sns[10]) begin
      st_next.t_ovl = 8'h00;
    end
    st_next.t_batt = hold_step(st_reg.t_batt, sns[7], st_reg.tick);
    // The beep counter wraps at the cadence itself, so a long run never shortens a period.
    if (st_reg.tick) begin
      st_next.t_beep = (st_reg.t_beep >= beep_last) ? 8'h00 : st_reg.t_beep + 8'h01;
    end

    case (st_reg.mode)
      ups_sup_pkg::UPS_OFF: begin
        if (hold_hit(st_reg.h_on, ups_sup_pkg::T_HOLD_ON) && st_reg.tick) begin
          st_next.mode    = sns[1] ? ups_sup_pkg::UPS_START : ups_sup_pkg::UPS_BATT;
          st_next.t_start = 8'h00;
        end else if (hold_hit(st_reg.h_sel, ups_sup_pkg::T_HOLD_MUTE) && st_reg.tick) begin
          st_next.mode    = ups_sup_pkg::UPS_SETTING;
          st_next.out_sel = 3'h0;
        end
      end
      ups_sup_pkg::UPS_START: begin
        st_next.t_start = hold_step(st_reg.t_start, 1'b1, st_reg.tick);
        if (hold_hit(st_reg.t_start, ups_sup_pkg::T_START_BYP) && st_reg.tick) begin
          st_next.mode = ups_sup_pkg::UPS_LINE;
        end
      end
      ups_sup_pkg::UPS_SETTING: begin
        if (press[2]) begin
          st_next.out_sel = (st_reg.out_sel == ups_sup_pkg::SEL_LAST) ? 3'h0 : st_reg.out_sel + 3'h1;
        end else if (press[0] || press[1]) begin
          st_next.out_sel = (st_reg.out_sel == 3'h0) ? ups_sup_pkg::SEL_LAST : st_reg.out_sel - 3'h1;
        end
        if (hold_hit(st_reg.h_sel, ups_sup_pkg::T_HOLD_DEF) && st_reg.tick) begin
          st_next.mode = ups_sup_pkg::UPS_OFF;
        end
      end
      ups_sup_pkg::UPS_FAIL: begin
        if (hold_hit(st_reg.h_off, ups_sup_pkg::T_HOLD_ON) && st_reg.tick) begin
          st_next.mode = ups_sup_pkg::UPS_OFF;
        end
      end
      default: begin
        // Running modes: line, battery, bypass and standby.
        if (st_reg.mode == ups_sup_pkg::UPS_LINE && line_fail) begin
          st_next.mode = ups_sup_pkg::UPS_BATT;
        end else if (st_reg.mode == ups_sup_pkg::UPS_BATT && sns[1]) begin
          st_next.mode = ups_sup_pkg::UPS_LINE;
        end
        if (press[2] && st_reg.mode != ups_sup_pkg::UPS_STANDBY) begin
          st_next.out_sel = (st_reg.out_sel == ups_sup_pkg::SEL_LAST) ? 3'h0 : st_reg.out_sel + 3'h1;
        end
        if (hold_hit(st_reg.h_sel, ups_sup_pkg::T_HOLD_DEF) && st_reg.tick) begin
          st_next.out_def = 1'b1;
          st_next.out_sel = 3'h0;
        end
        if ((hold_hit(st_reg.h_on, ups_sup_pkg::T_HOLD_MUTE) || hold_hit(st_reg.h_off, ups_sup_pkg::T_HOLD_MUTE))
            && st_reg.tick && !any_warn) begin
          st_next.out_mute = 1'b1;
        end
        if (hold_hit(st_reg.h_on_sel, ups_sup_pkg::T_HOLD_MUTE) && st_reg.tick && sns[1]) begin
          st_next.mode = ups_sup_pkg::UPS_BYPASS;
        end
        if (hold_hit(st_reg.h_on_off, ups_sup_pkg::T_HOLD_MUTE) && st_reg.tick &&
            (st_reg.mode == ups_sup_pkg::UPS_LINE || economy_mode || converter_mode)) begin
          st_next.out_test = 1'b1;
        end
        if (hold_hit(st_reg.h_off, ups_sup_pkg::T_HOLD_ON) && st_reg.tick) begin
          st_next.mode = sns[1] ? ups_sup_pkg::UPS_STANDBY : ups_sup_pkg::UPS_OFF;
        end
        if (line_fail && sns[2]) begin
          st_next.mode = ups_sup_pkg::UPS_OFF;
        end
        if (ovl && st_reg.mode == ups_sup_pkg::UPS_BATT) begin
          st_next.mode = ups_sup_pkg::UPS_FAIL;
        end else if (ovl && st_reg.mode == ups_sup_pkg::UPS_LINE &&
                     ((sns[10] && hold_hit(st_reg.t_ovl, ups_sup_pkg::T_OVL_HIGH)) ||
                      hold_hit(st_reg.t_ovl, ups_sup_pkg::T_OVL_MID)) && st_reg.tick) begin
          st_next.mode = ups_sup_pkg::UPS_BYPASS;
        end
        if (hard_fault || (sns[7] && hold_hit(st_reg.t_batt, ups_sup_pkg::T_BATT_WARN) && st_reg.tick)) begin
          st_next.mode = ups_sup_pkg::UPS_FAIL;
        end
      end
    endcase
    if (st_next.mode == ups_sup_pkg::UPS_OFF || st_reg.out_test && self_test_done) begin
      st_next.out_test = 1'b0;
    end
    if (any_warn || st_next.mode == ups_sup_pkg::UPS_OFF) begin
      st_next.out_mute = 1'b0;
    end

    // Fault code priority: inverter, temperature, bus, battery.
    if (st_reg.inv_latched || sns[8]) begin
      st_next.out_code = ups_sup_pkg::FC_INV;
    end else if (!sns[4]) begin
      st_next.out_code = ups_sup_pkg::FC_TEMP;
    end else if (sns[3]) begin
      st_next.out_code = ups_sup_pkg::FC_BUS;
    end else if (st_reg.mode == ups_sup_pkg::UPS_FAIL && sns[7]) begin
      st_next.out_code = ups_sup_pkg::FC_BATT;
    end else if (st_reg.mode == ups_sup_pkg::UPS_FAIL && ovl) begin
      st_next.out_code = ups_sup_pkg::FC_OVL;
    end else if (st_reg.mode == ups_sup_pkg::UPS_OFF) begin
      st_next.out_code = ups_sup_pkg::FC_NONE;
    end

    // Pulse-by-pulse limit: blank from the overcurrent until the next pulse starts.
    st_next.pulse_prev = sns[0];
    if (sns[9]) begin
      st_next.oc_blank = 1'b1;
    end else if (sns[0] && !st_reg.pulse_prev) begin
      st_next.oc_blank = 1'b0;
    end

    st_next.out_inv_en = (st_next.mode == ups_sup_pkg::UPS_START || st_next.mode == ups_sup_pkg::UPS_LINE ||
                          st_next.mode == ups_sup_pkg::UPS_BATT) && !st_next.inv_latched && !sns[8];
    st_next.out_gate   = st_next.out_inv_en && !st_next.oc_blank && !sns[9];
    // Current limiting is not an input here, so the relay only follows mode.
    st_next.out_byp    = st_next.mode == ups_sup_pkg::UPS_START || st_next.mode == ups_sup_pkg::UPS_BYPASS;
    st_next.out_warn   = any_warn;
    st_next.out_set    = st_next.mode == ups_sup_pkg::UPS_SETTING;

    if (st_reg.inv_latched) begin
      st_next.out_buz = ~st_reg.out_mute;
    end else if (st_reg.mode == ups_sup_pkg::UPS_BATT && !st_reg.out_mute) begin
      st_next.out_buz = st_reg.t_beep < 8'(ups_sup_pkg::T_BEEP_LEN);
    end else begin
      st_next.out_buz = 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      st_reg          <= '0;
      st_reg.mode     <= ups_sup_pkg::UPS_OFF;
      st_reg.out_code <= ups_sup_pkg::FC_NONE;
      st_reg.s1_sns   <= ups_sup_pkg::SNS_RST;
      st_reg.s2_sns   <= ups_sup_pkg::SNS_RST;
    end else if (ce) begin
      st_reg <= st_next;
    end
  end

  assign inv_gate_en      = st_reg.out_gate;
  assign inv_enable       = st_reg.out_inv_en;
  assign relay_bypass     = st_reg.out_byp;
  assign buzzer           = st_reg.out_buz;
  assign warning          = st_reg.out_warn;
  assign muted            = st_reg.out_mute;
  assign fault_code       = st_reg.out_code;
  assign disp_sel         = st_reg.out_sel;
  assign setting_mode     = st_reg.out_set;
  assign self_test        = st_reg.out_test;
  assign defaults_restore = st_reg.out_def;

  // ==========================================================
  // Assertions
  property p_inv_off;
    @(posedge clk_sys) disable iff (!rst_n) st_reg.inv_latched |-> (!inv_enable && !inv_gate_en);
  endproperty
  a_inv_off: assert property (p_inv_off) else $error("Inverter enabled while failure latched.");

  property p_inv_hold;
    @(posedge clk_sys) disable iff (!rst_n)
      (ce && st_reg.inv_latched && st_reg.mode != ups_sup_pkg::UPS_OFF && !st_reg.s2_sns[5]) |=> st_reg.inv_latched;
  endproperty
  a_inv_hold: assert property (p_inv_hold) else $error("Inverter failure latch dropped early.");

  property p_batt_fail;
    @(posedge clk_sys) disable iff (!rst_n)
      (ce && st_reg.mode == ups_sup_pkg::UPS_BATT && st_reg.s2_sns[11] && !st_reg.s2_sns[1])
      |=> st_reg.mode == ups_sup_pkg::UPS_FAIL;
  endproperty
  a_batt_fail: assert property (p_batt_fail) else $error("Battery overload did not fail.");

  property p_gate_oc;
    @(posedge clk_sys) disable iff (!rst_n) (ce && st_reg.s2_sns[9]) |=> !inv_gate_en;
  endproperty
  a_gate_oc: assert property (p_gate_oc) else $error("Gate active during overcurrent.");

  property p_start_byp;
    @(posedge clk_sys) disable iff (!rst_n) (st_reg.mode == ups_sup_pkg::UPS_START) |-> relay_bypass;
  endproperty
  a_start_byp: assert property (p_start_byp) else $error("Start without bypass relay.");

  property p_mute_refused;
    @(posedge clk_sys) disable iff (!rst_n) (ce && st_reg.out_warn && st_reg.s2_sns[8]) |=> ##1 !muted;
  endproperty
  a_mute_refused: assert property (p_mute_refused) else $error("Muted during inverter fault.");

  property p_temp_code;
    @(posedge clk_sys) disable iff (!rst_n)
      (ce && !st_reg.s2_sns[4] && !st_reg.inv_latched && !st_reg.s2_sns[8]) |=> fault_code == ups_sup_pkg::FC_TEMP;
  endproperty
  a_temp_code: assert property (p_temp_code) else $error("Temperature code missing.");

  property p_rsd;
    @(posedge clk_sys) disable iff (!rst_n)
      (ce && st_reg.mode == ups_sup_pkg::UPS_LINE && st_reg.s2_sns[1] && !st_reg.s2_sns[11] &&
       st_reg.s2_sns[2] && !hard_fault && !st_reg.s2_sns[7]) |=> st_reg.mode != ups_sup_pkg::UPS_OFF;
  endproperty
  a_rsd: assert property (p_rsd) else $error("Remote shutdown honoured with mains.");

endmodule

// ==== bench/ups_sup_panel.sv ====
// Front-panel model: three push keys with pull-ups, so a released key reads high.
// Assumes the bench calls press right after a clock edge, from one thread at a time.
module ups_sup_panel (
  input  wire logic clk_sys,
  output logic      key_on_n,
  output logic      key_off_n,
  output logic      key_sel_n
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    {key_on_n, key_off_n, key_sel_n} = 3'h7;
  end
  // ==========================================================
  // Key presses
  // The operator keeps the keys down for the whole hold time given.
  task automatic press(input logic [2:0] keys, input int cycles);
    {key_on_n, key_off_n, key_sel_n} = ~keys;
    repeat (cycles) @(posedge clk_sys);
    #5;
    {key_on_n, key_off_n, key_sel_n} = 3'h7;
  endtask
endmodule

// ==== bench/ups_sup_test.sv ====
// Self-checking bench for the UPS protection and panel supervisor.
// Assumes short tick and debounce parameters, so one second is 40 clocks.
module ups_sup_test;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int S = 40;
  logic       clk_sys = 1'b0, rst_n = 1'b0, pwm_pulse = 1'b0, self_test_done = 1'b0;
  logic       mains_ok = 1'b0, load_over_110 = 1'b0, load_over_130 = 1'b0, inv_fail = 1'b0;
  logic       batt_low = 1'b0, thermal_closed = 1'b1, bus_fault = 1'b0, remote_shutdown = 1'b0;
  logic       inv_overcurrent = 1'b0, key_on_n, key_off_n, key_sel_n;
  logic       batt_out_window = 1'b0, batt_depleted = 1'b0, economy_mode = 1'b0, setting_mode, defaults_restore;
  logic       inv_gate_en, inv_enable, relay_bypass, buzzer, warning, muted, self_test;
  logic [3:0] fault_code, n;
  logic [2:0] disp_sel;
  int         fail_count = 0, tests_run = 0, cycles = 0, def_seen = 0;

  always #25 clk_sys = ~clk_sys;
  always begin
    repeat (8) @(posedge clk_sys);
    #5 pwm_pulse = ~pwm_pulse;
  end
  always @(posedge clk_sys) begin
    cycles++;
    def_seen += int'(defaults_restore === 1'b1);
    if (cycles == 20000) begin
      fail_count++;
      wrap_up();
    end
  end

  ups_sup #(.DEB_CYC(2), .TICK_CYC(4)) ups_sup_i (
    .clk_sys, .rst_n, .ce(1'b1), .key_on_n, .key_off_n, .key_sel_n, .mains_ok, .load_over_110,
    .load_over_130, .inv_overcurrent, .inv_fail, .batt_out_window, .batt_low,
    .batt_depleted, .thermal_closed, .bus_fault, .remote_shutdown, .self_test_done,
    .economy_mode, .converter_mode(1'b0), .pwm_pulse, .inv_gate_en, .inv_enable,
    .relay_bypass, .buzzer, .warning, .muted, .fault_code, .disp_sel, .setting_mode,
    .self_test, .defaults_restore);
  ups_sup_panel ups_sup_panel_i (.clk_sys, .key_on_n, .key_off_n, .key_sel_n);

  // ==========================================================
  // Shared tasks
  task automatic cyc(input int k);
    repeat (k) @(posedge clk_sys);
    #5;
  endtask
  task automatic check(input string what, input logic [3:0] seen, input logic [3:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wrap_up();
    if (fail_count == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // Reset with every sensor idle; the unit stays off.
  task automatic reset_dut(input logic mains);
    {load_over_110, load_over_130, inv_fail, bus_fault, batt_low, remote_shutdown} = 6'h00;
    {batt_out_window, batt_depleted, economy_mode} = 3'h0;
    thermal_closed = 1'b1;
    mains_ok = mains;
    rst_n = 1'b0;
    cyc(4);
    rst_n = 1'b1;
    cyc(2);
  endtask
  // Reset, then switch on; with mains the wait covers the whole bypass start period.
  task automatic power_on(input logic mains);
    reset_dut(mains);
    ups_sup_panel_i.press(3'h4, 100);
    cyc(mains ? 12 * S : 2);
  endtask
  // Counting rising edges over a whole number of periods gives an exact count.
  task automatic beeps(input int k, output logic [3:0] cnt);
    logic prev;
    prev = buzzer;
    cnt = 4'h0;
    repeat (k) begin
      cyc(1);
      if (buzzer === 1'b1 && prev !== 1'b1) cnt++;
      prev = buzzer;
    end
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_start();
    power_on(1'b1);
    rst_n = 1'b0;
    cyc(4);
    rst_n = 1'b1;
    cyc(2);
    check("relay_rst", relay_bypass, 4'h0);
    check("fault_rst", fault_code, ups_sup_pkg::FC_NONE);
    ups_sup_panel_i.press(3'h4, S);
    cyc(S);
    check("inv_short", inv_enable, 4'h0);
    ups_sup_panel_i.press(3'h4, 5 * S / 2);
    cyc(4 * S);
    check("relay_start", relay_bypass, 4'h1);
    check("inv_start", inv_enable, 4'h1);
    cyc(7 * S);
    check("relay_line", relay_bypass, 4'h0);
    remote_shutdown = 1'b1;
    cyc(S);
    check("inv_remote_line", inv_enable, 4'h1);
    remote_shutdown = 1'b0;
    inv_overcurrent = 1'b1;
    cyc(6);
    check("gate_limit", inv_gate_en, 4'h0);
    check("relay_limit", relay_bypass, 4'h0);
    inv_overcurrent = 1'b0;
    cyc(24);
    check("gate_resume", inv_gate_en, 4'h1);
    for (int i = 1; i <= 6; i++) begin
      ups_sup_panel_i.press(3'h1, 12);
      cyc(12);
      check("disp_sel", {1'b0, disp_sel}, 4'(i % 5));
    end
    ups_sup_panel_i.press(3'h4, 6 * S);
    cyc(4);
    check("muted", muted, 4'h1);
    ups_sup_panel_i.press(3'h6, 6 * S);
    cyc(4);
    check("self_test", self_test, 4'h1);
    self_test_done = 1'b1;
    cyc(8);
    check("self_test_end", self_test, 4'h0);
    self_test_done = 1'b0;
    ups_sup_panel_i.press(3'h2, 5 * S / 2);
    cyc(8);
    check("inv_standby", inv_enable, 4'h0);
  endtask
  task automatic t_overload(input logic high, input int t_early, input int t_late);
    power_on(1'b1);
    load_over_110 = 1'b1;
    load_over_130 = high;
    cyc(t_early);
    check("relay_early", relay_bypass, 4'h0);
    check("warning", warning, 4'h1);
    cyc(t_late - t_early);
    check("relay_late", relay_bypass, 4'h1);
  endtask
  task automatic t_fault(input int k, input logic [3:0] code);
    power_on(1'b1);
    inv_fail = (k == 0);
    thermal_closed = (k != 1);
    bus_fault = (k == 2);
    cyc(8);
    check("fault_code", fault_code, code);
    if (k == 0) begin
      check("inv_fault", inv_enable, 4'h0);
      inv_fail = 1'b0;
      ups_sup_panel_i.press(3'h4, 6 * S);
      cyc(4);
      check("fault_latch", fault_code, code);
      check("mute_refused", muted, 4'h0);
      check("buzz_hold", buzzer, 4'h1);
      batt_depleted = 1'b1;
      cyc(8);
      check("buzz_depleted", buzzer, 4'h0);
    end
  endtask
  task automatic t_panel();
    power_on(1'b1);
    ups_sup_panel_i.press(3'h5, 6 * S);
    cyc(4);
    check("relay_key_bypass", relay_bypass, 4'h1);
    ups_sup_panel_i.press(3'h6, 6 * S);
    cyc(4);
    check("test_refused", self_test, 4'h0);
    economy_mode = 1'b1;
    ups_sup_panel_i.press(3'h6, 6 * S);
    cyc(4);
    check("test_economy", self_test, 4'h1);
    ups_sup_panel_i.press(3'h1, 11 * S);
    cyc(4);
    check("defaults", 4'(def_seen), 4'h1);
    check("disp_default", {1'b0, disp_sel}, 4'h0);
    reset_dut(1'b1);
    ups_sup_panel_i.press(3'h1, 6 * S);
    cyc(4);
    check("setting", setting_mode, 4'h1);
    ups_sup_panel_i.press(3'h1, 12);
    cyc(12);
    check("set_next", {1'b0, disp_sel}, 4'h1);
    ups_sup_panel_i.press(3'h4, 12);
    cyc(12);
    check("set_prev_on", {1'b0, disp_sel}, 4'h0);
    ups_sup_panel_i.press(3'h2, 12);
    cyc(12);
    check("set_prev_off", {1'b0, disp_sel}, 4'h4);
  endtask
  task automatic t_battery();
    power_on(1'b0);
    cyc(S);
    check("inv_batt", inv_enable, 4'h1);
    beeps(16 * S, n);
    check("beeps_line", n, 4'h4);
    batt_low = 1'b1;
    cyc(2 * S);
    beeps(4 * S, n);
    check("beeps_low", n, 4'h4);
    remote_shutdown = 1'b1;
    cyc(S);
    check("inv_remote", inv_enable, 4'h0);
    power_on(1'b0);
    {load_over_110, load_over_130} = 2'h3;
    cyc(3 * S);
    check("relay_fail", relay_bypass, 4'h0);
    check("fault_fail", fault_code, ups_sup_pkg::FC_OVL);
    power_on(1'b0);
    batt_out_window = 1'b1;
    cyc(S);
    check("warn_batt", warning, 4'h1);
    check("inv_batt_warn", inv_enable, 4'h1);
    cyc(5 * S);
    check("inv_batt_off", inv_enable, 4'h0);
    check("fault_batt", fault_code, ups_sup_pkg::FC_BATT);
  endtask

  initial begin
    t_start();
    t_panel();
    t_overload(1'b1, 5 * S / 4, 15 * S / 8);
    t_overload(1'b0, 11 * S, 13 * S);
    t_fault(0, ups_sup_pkg::FC_INV);
    t_fault(1, ups_sup_pkg::FC_TEMP);
    t_fault(2, ups_sup_pkg::FC_BUS);
    t_battery();
    wrap_up();
  end
endmodule
